// ==== hdl/uhcsr_pkg.sv ====
// constants for the hub control and status register bank
package uhcsr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NPORTS = 3;

  // register byte addresses
  localparam logic [7:0] ADR_SCRATCH = 8'h0f;
  localparam logic [7:0] ADR_HADDR   = 8'h10;
  localparam logic [7:0] ADR_IRQF    = 8'h11;
  localparam logic [7:0] ADR_IRQE    = 8'h12;
  localparam logic [7:0] ADR_CFGST   = 8'h13;
  localparam logic [7:0] ADR_EP1CHG  = 8'h14;
  localparam logic [7:0] ADR_PSEL    = 8'h15;
  localparam logic [7:0] ADR_PCMD    = 8'h16;
  localparam logic [7:0] ADR_PSTATE  = 8'h17;
  localparam logic [7:0] ADR_PCHG    = 8'h18;

  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_CFGST = 8'h30;

  // flag / enable bit positions
  localparam int B_NAK     = 7;
  localparam int B_SOF     = 6;
  localparam int B_RESUME  = 5;
  localparam int B_SUSPEND = 4;
  localparam int B_RX0     = 1;
  localparam int B_TX0     = 0;
  localparam logic [7:0] IRQ_MASK = 8'h73;

  // config/status bit positions
  localparam int B_CONFIG  = 7;
  localparam int B_RWAKE   = 6;
  localparam int B_GANGED_POWER_SELECT   = 5;
  localparam int B_GANGED_OVERCURRENT_SELECT   = 4;
  localparam int B_OVCHG   = 3;
  localparam int B_OV      = 1;

  // port state bit positions
  localparam int B_LS      = 6;
  localparam int B_PWR     = 5;
  localparam int B_RST     = 4;
  localparam int B_POV     = 3;
  localparam int B_SUSP    = 2;
  localparam int B_EN      = 1;
  localparam int B_CONN    = 0;

  // port change bit positions
  localparam int B_RSTDONE = 4;

  // port commands
  typedef enum logic [2:0] {
    UHCSR_PWR_OFF = 3'h0,
    UHCSR_PWR_ON  = 3'h1,
    UHCSR_DISABLE = 3'h2,
    UHCSR_RST_EN  = 3'h3,
    UHCSR_SUSPEND = 3'h4,
    UHCSR_RESUME  = 3'h5
  } uhcsr_cmd_t;

  // timing
  localparam int CLK_MHZ       = 250;
  localparam int RST_TIME_MS   = 10;
  localparam int RST_CYCLES    = RST_TIME_MS * 1000 * CLK_MHZ;
endpackage : uhcsr_pkg

// ==== hdl/uhcsr_regs.sv ====
// hub control and status register bank with per-port state
//
// Contract
// - scratch byte is read/write any time, not cleared by bus reset.
// - seven-bit hub address in low bits, top bit reserved, cleared by bus reset.
// - flags read one while pending; a read clears the flag register.
// - frame start flag bit 6 sets on real or synthesised frame start.
// - resume detect sets flag bit 5 and, with enable bit 5 set, raises a wake output.
// - suspend detect sets flag bit 4.
// - endpoint-0 receive done sets bit 1, transmit done sets bit 0.
// - each source raises the interrupt only with its enable set.
// - enable bit 7 lets nak or stall transactions interrupt too.
// - while configured bit is zero, all downstream ports drive se0.
// - remote wake enable gates wake requests from port and change events.
// - config bit 5 selects ganged power control.
// - config bit 4 selects ganged over-current reporting.
// - status bit 3 latches any global over-current change; firmware clears.
// - status bit 1 follows the inverted active-low over-current pin.
// - endpoint-1 bitmap holds four bits; in token gets data or nak.
// - any port change bit sets that port's bitmap bit.
// - two-bit index selects port 1, 2 or 3.
// - command write acts on indexed port with six encoded commands.
// - port state bit 6 shows low-speed attach.
// - port state bit 5 shows power, from commands or over-current.
// - port state bit 4 is one while reset signalling is driven.
// - port state bit 3 follows port over-current, zero when ganged.
// - about 10 ms after reset command, reset-done change bit sets.
// - port state bit 1 shows enable, updated by commands.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module uhcsr_regs #(
  parameter int RST_CNT = uhcsr_pkg::RST_CYCLES
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         usb_reset_i,
  // register port
  input  wire logic [uhcsr_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [uhcsr_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [uhcsr_pkg::DATA_W-1:0] rdata_o,
  // serial engine events
  input  wire logic                         sof_rx_i,
  input  wire logic                         sof_timer_i,
  input  wire logic                         resume_det_i,
  input  wire logic                         suspend_det_i,
  input  wire logic                         ep0_rx_done_i,
  input  wire logic                         ep0_tx_done_i,
  input  wire logic                         nak_stall_i,
  input  wire logic                         ep1_in_token_i,
  input  wire logic                         hub_suspended_i,
  // port sense inputs
  input  wire logic                         overcurrent_in_n_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] port_oc_n_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] low_speed_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] connect_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] conn_change_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] port_error_i,
  input  wire logic [uhcsr_pkg::NPORTS-1:0] resume_done_i,
  // outputs
  output logic                              irq_o,
  output logic                              wake_o,
  output logic                              remote_wake_req_o,
  output logic      [6:0]                   hub_addr_o,
  output logic      [uhcsr_pkg::NPORTS-1:0] port_se0_o,
  output logic      [uhcsr_pkg::NPORTS-1:0] port_reset_o,
  output logic      [uhcsr_pkg::NPORTS-1:0] port_power_o,
  output logic      [uhcsr_pkg::NPORTS-1:0] port_suspend_o,
  output logic      [uhcsr_pkg::NPORTS-1:0] port_enable_o,
  output logic                              ep1_send_o,
  output logic                              ep1_nak_o,
  output logic      [uhcsr_pkg::DATA_W-1:0] ep1_data_o
);
  import uhcsr_pkg::*;

  localparam int CW = $clog2(RST_CNT + 1);

  // decode of index to one-hot port select, shared by reads and writes
  function automatic logic [NPORTS-1:0] port_hot(input logic [1:0] idx);
    logic [NPORTS-1:0] h;
    h = '0;
    case (idx)
      2'h1:    h = 3'h1;
      2'h2:    h = 3'h2;
      2'h3:    h = 3'h4;
      default: h = '0;
    endcase
    return h;
  endfunction : port_hot

  logic [7:0]        scratch_r;
  logic [6:0]        haddr_r;
  logic [7:0]        flags_r;
  logic [7:0]        enables_r;
  logic              cfg_r;
  logic              rwake_r;
  logic              ganged_power_select_r;
  logic              ganged_overcurrent_select_r;
  logic              ovchg_r;
  logic              ov_r;
  logic [1:0]        psel_r;
  logic [2:0]        pcmd_r;
  logic [NPORTS-1:0] hot;
  logic [7:0]        flag_set;
  logic              rd_flags;
  logic              wr_cmd;
  logic [7:0]        pstate [NPORTS];
  logic [4:0]        pchg   [NPORTS];
  logic [NPORTS-1:0] pchg_any;
  logic [3:0]        ep1_bits;
  logic              cmd_rst_any;
  logic [NPORTS-1:0] oc_vec;

  assign hot      = port_hot(psel_r);
  assign rd_flags = rd_i && (addr_i == ADR_IRQF);
  assign wr_cmd   = wr_i && (addr_i == ADR_PCMD);

  ////////////////////////////////////////////////////////////////////////////
  // scratch, address, enables, index, command

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scratch_r <= RST_ZERO;
    end else if (wr_i && addr_i == ADR_SCRATCH) begin
      scratch_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || usb_reset_i) begin
      haddr_r <= '0;
    end else if (wr_i && addr_i == ADR_HADDR) begin
      haddr_r <= wdata_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      enables_r <= RST_ZERO;
      psel_r    <= '0;
      pcmd_r    <= '0;
    end else begin
      if (wr_i && addr_i == ADR_IRQE) enables_r <= wdata_i & (IRQ_MASK | 8'h80);
      if (wr_i && addr_i == ADR_PSEL) psel_r <= wdata_i[1:0];
      if (wr_cmd) pcmd_r <= wdata_i[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags

  always_comb begin
    flag_set = '0;
    flag_set[B_SOF]     = sof_rx_i | sof_timer_i;
    flag_set[B_RESUME]  = resume_det_i;
    flag_set[B_SUSPEND] = suspend_det_i;
    flag_set[B_RX0]     = ep0_rx_done_i;
    flag_set[B_TX0]     = ep0_tx_done_i;
  end

  // clear on read, a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_r <= RST_ZERO;
    end else begin
      flags_r <= ((rd_flags ? 8'h00 : flags_r) | flag_set) & IRQ_MASK;
    end
  end

  // enable gating, nak events pass only with bit 7
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_r & enables_r & IRQ_MASK)
               | (enables_r[B_NAK] & nak_stall_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) wake_o <= 1'b0;
    else         wake_o <= flags_r[B_RESUME] & enables_r[B_RESUME];
  end

  ////////////////////////////////////////////////////////////////////////////
  // hub configuration and over-current

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_r   <= RST_CFGST[B_CONFIG];
      rwake_r <= RST_CFGST[B_RWAKE];
      ganged_power_select_r <= RST_CFGST[B_GANGED_POWER_SELECT];
      ganged_overcurrent_select_r <= RST_CFGST[B_GANGED_OVERCURRENT_SELECT];
    end else if (wr_i && addr_i == ADR_CFGST) begin
      cfg_r   <= wdata_i[B_CONFIG];
      rwake_r <= wdata_i[B_RWAKE];
      ganged_power_select_r <= wdata_i[B_GANGED_POWER_SELECT];
      ganged_overcurrent_select_r <= wdata_i[B_GANGED_OVERCURRENT_SELECT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) ov_r <= 1'b0;
    else         ov_r <= ~overcurrent_in_n_i;
  end

  // sticky change, write one clears, change wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ovchg_r <= 1'b0;
    end else if (ov_r != ~overcurrent_in_n_i) begin
      ovchg_r <= 1'b1;
    end else if (wr_i && addr_i == ADR_CFGST && wdata_i[B_OVCHG]) begin
      ovchg_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) port_se0_o <= '1;
    else         port_se0_o <= cfg_r ? '0 : '1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port state

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic          pwr_r;
    logic          en_r;
    logic          susp_r;
    logic          rst_r;
    logic [CW-1:0] cnt_r;
    logic          cmd_here;
    logic          oc;
    logic          oc_d_r;
    logic [4:0]    chg_set;
    logic          chg_clr;

    // only the indexed port sees a command
    assign cmd_here = wr_cmd && hot[p];
    // ganged mode uses the global pin
    assign oc = ganged_overcurrent_select_r ? ov_r : ~port_oc_n_i[p];
    assign chg_clr = wr_i && addr_i == ADR_PCHG && hot[p];

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        pwr_r  <= 1'b0;
        en_r   <= 1'b0;
        susp_r <= 1'b0;
        rst_r  <= 1'b0;
        cnt_r  <= '0;
      end else if (oc) begin
        pwr_r  <= 1'b0;
        en_r   <= 1'b0;
        rst_r  <= 1'b0;
        cnt_r  <= '0;
      end else if (cmd_here) begin
        case (uhcsr_cmd_t'(wdata_i[2:0]))
          UHCSR_PWR_OFF: begin
            pwr_r <= 1'b0;
            en_r  <= 1'b0;
          end
          UHCSR_PWR_ON:  pwr_r <= 1'b1;
          UHCSR_DISABLE: en_r  <= 1'b0;
          UHCSR_RST_EN: begin
            rst_r <= 1'b1;
            cnt_r <= CW'(RST_CNT);
          end
          UHCSR_SUSPEND: susp_r <= 1'b1;
          UHCSR_RESUME:  susp_r <= 1'b0;
          default:       pwr_r  <= pwr_r;
        endcase
      end else if (rst_r) begin
        if (cnt_r == CW'(1)) begin
          rst_r <= 1'b0;
          en_r  <= 1'b1;
        end
        cnt_r <= cnt_r - CW'(1);
      end else if (port_error_i[p]) begin
        en_r <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) oc_d_r <= 1'b0;
      else         oc_d_r <= oc;
    end

    always_comb begin
      chg_set = '0;
      chg_set[B_RSTDONE] = rst_r && cnt_r == CW'(1) && !oc && !cmd_here;
      chg_set[3] = !ganged_overcurrent_select_r && (oc != oc_d_r);
      chg_set[2] = resume_done_i[p];
      chg_set[1] = port_error_i[p] && en_r;
      chg_set[0] = conn_change_i[p];
    end

    // sticky change bits, write one clears, set wins
    always_ff @(posedge clk_i) begin
      if (reset_i) pchg[p] <= '0;
      else pchg[p] <= (pchg[p] & ~(chg_clr ? wdata_i[4:0] : 5'h00)) | chg_set;
    end

    always_comb begin
      pstate[p] = '0;
      pstate[p][B_LS]   = low_speed_i[p];
      pstate[p][B_PWR]  = pwr_r;
      pstate[p][B_RST]  = rst_r;
      pstate[p][B_POV]  = ganged_overcurrent_select_r ? 1'b0 : oc;
      pstate[p][B_SUSP] = susp_r;
      pstate[p][B_EN]   = en_r;
      pstate[p][B_CONN] = connect_i[p];
    end

    // any change bit flags the port
    assign pchg_any[p] = |pchg[p];

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        port_reset_o[p]   <= 1'b0;
        port_power_o[p]   <= 1'b0;
        port_suspend_o[p] <= 1'b0;
        port_enable_o[p]  <= 1'b0;
      end else begin
        port_reset_o[p]   <= rst_r;
        port_power_o[p]   <= ganged_power_select_r ? g_port[0].pwr_r : pwr_r;
        port_suspend_o[p] <= susp_r;
        port_enable_o[p]  <= en_r;
      end
    end
  end

  // hub bit plus one bit per port
  assign ep1_bits = {pchg_any, ovchg_r};

  ////////////////////////////////////////////////////////////////////////////
  // endpoint-1 answer and remote wake

  // data if any bit, else nak
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ep1_send_o <= 1'b0;
      ep1_nak_o  <= 1'b0;
      ep1_data_o <= RST_ZERO;
    end else begin
      ep1_send_o <= ep1_in_token_i && (|ep1_bits);
      ep1_nak_o  <= ep1_in_token_i && !(|ep1_bits);
      ep1_data_o <= {4'h0, ep1_bits};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) remote_wake_req_o <= 1'b0;
    else remote_wake_req_o <= hub_suspended_i && rwake_r
                              && ((|conn_change_i) || resume_det_i || (|ep1_bits));
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) hub_addr_o <= '0;
    else         hub_addr_o <= haddr_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= RST_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        ADR_SCRATCH: rdata_o <= scratch_r;
        ADR_HADDR:   rdata_o <= {1'b0, haddr_r};
        ADR_IRQF:    rdata_o <= flags_r;
        ADR_IRQE:    rdata_o <= enables_r;
        ADR_CFGST:   rdata_o <= {cfg_r, rwake_r, ganged_power_select_r, ganged_overcurrent_select_r, ovchg_r, 1'b0, ov_r, 1'b0};
        ADR_EP1CHG:  rdata_o <= {4'h0, ep1_bits};
        ADR_PSEL:    rdata_o <= {6'h00, psel_r};
        ADR_PCMD:    rdata_o <= (hot != '0) ? {5'h00, pcmd_r} : RST_ZERO;
        ADR_PSTATE:  rdata_o <= (psel_r == 2'h0) ? RST_ZERO : pstate[psel_r - 2'h1];
        ADR_PCHG:    rdata_o <= (psel_r == 2'h0) ? RST_ZERO : {3'h0, pchg[psel_r - 2'h1]};
        default:     rdata_o <= RST_ZERO;
      endcase
    end else begin
      rdata_o <= RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_flag_read;
    rd_i && addr_i == ADR_IRQF && !(|flag_set);
  endsequence

  a_flags_clear_read: assert property (@(posedge clk_i) disable iff (reset_i)
    s_flag_read |=> flags_r == 8'h00) else $error("flags not cleared by read");
  a_sof_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (sof_rx_i || sof_timer_i) |=> flags_r[B_SOF]) else $error("frame flag missing");
  a_resume_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    resume_det_i |=> flags_r[B_RESUME]) else $error("resume flag missing");
  a_irq_gated: assert property (@(posedge clk_i) disable iff (reset_i)
    (enables_r == 8'h00 && !$past(reset_i)) |=> !irq_o) else $error("irq not gated");
  a_se0_unconfig: assert property (@(posedge clk_i) disable iff (reset_i)
    !cfg_r |=> port_se0_o == '1) else $error("se0 missing");
  a_ovchg_latch: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(overcurrent_in_n_i) |=> ovchg_r) else $error("over-current change lost");
  a_ov_follow: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 ov_r == !$past(overcurrent_in_n_i)) else $error("over-current bit wrong");
  a_ep1_nak: assert property (@(posedge clk_i) disable iff (reset_i)
    (ep1_in_token_i && ep1_bits == 4'h0) |=> ep1_nak_o && !ep1_send_o)
    else $error("endpoint-1 answer wrong");
  a_rst_status: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_rst_any |=> ##1 ((|port_reset_o) || $past(|(hot & oc_vec), 2)))
    else $error("reset not shown");

  // port reset output lags the internal reset flag by one cycle
  assign cmd_rst_any = wr_cmd && hot != '0 && wdata_i[2:0] == UHCSR_RST_EN;
  for (genvar q = 0; q < NPORTS; q++) begin : g_ocv
    assign oc_vec[q] = g_port[q].oc;
  end
endmodule : uhcsr_regs

// ==== verification/uhcsr_far_model.sv ====
// far-side model: upstream host events and three downstream port devices
`timescale 1ns/1ps
module uhcsr_far_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // bench requests
  input  wire logic [13:0] ev_i,
  input  wire logic       glob_oc_i,
  input  wire logic [2:0] port_oc_i,
  input  wire logic [2:0] attach_i,
  input  wire logic [2:0] ls_dev_i,
  // toward the block
  output logic [5:0] hub_ev_o = 6'h00,
  output logic       nak_o = 1'b0,
  output logic       token_o = 1'b0,
  output logic [2:0] conn_chg_o = 3'h0,
  output logic [2:0] res_done_o = 3'h0,
  output logic       oc_n_o,
  output logic [2:0] port_oc_n_o,
  output logic [2:0] low_speed_o,
  output logic [2:0] connect_o,
  // from the block
  input  wire logic [2:0] port_power_i,
  input  wire logic       ep1_send_i,
  input  wire logic       ep1_nak_i,
  input  wire logic [7:0] ep1_data_i,
  // host view of endpoint 1
  output logic [1:0] resp_o = 2'h0,
  output logic [7:0] resp_data_o = 8'h00
);
  // one-cycle event pulses, launched after the edge
  always @(posedge clk_i) begin
    hub_ev_o <= reset_i ? 6'h00 : ev_i[5:0];
    nak_o <= reset_i ? 1'b0 : ev_i[6];
    token_o <= reset_i ? 1'b0 : ev_i[7];
    conn_chg_o <= reset_i ? 3'h0 : ev_i[10:8];
    res_done_o <= reset_i ? 3'h0 : ev_i[13:11];
  end
  assign oc_n_o = ~glob_oc_i;
  assign port_oc_n_o = ~port_oc_i;
  assign connect_o = attach_i & port_power_i;
  assign low_speed_o = ls_dev_i & connect_o;
  // host takes the byte or a nak
  always @(posedge clk_i) begin
    if (reset_i) begin
      resp_o <= 2'h0;
    end else if (ep1_send_i) begin
      resp_o <= 2'h2;
      resp_data_o <= ep1_data_i;
    end else if (ep1_nak_i) begin
      resp_o <= 2'h1;
    end
  end
endmodule : uhcsr_far_model

// ==== verification/usb_hub_control_status_regs_tb.sv ====
// self-checking bench for the hub register bank
`timescale 1ns/1ps
module usb_hub_control_status_regs_tb;
  import uhcsr_pkg::*;
  localparam int RCNT = 20;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        usb_reset_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [13:0] ev = 14'h0;
  logic        susp = 1'b0;
  logic        glob_oc = 1'b0;
  logic [2:0]  p_oc = 3'h0;
  logic [7:0]  rdata_o, ep1_data_o, resp_data;
  logic [5:0]  hev;
  logic [2:0]  cchg, rdone, pocn, lsp, conn, se0, pwr, prst, psus, pen;
  logic        nak, tok, ocn, irq_o, wake_o, rwake, send, ep1nak;
  logic [1:0]  resp;
  logic [6:0]  hub_addr_o;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  fl [6] = '{8'h40, 8'h40, 8'h20, 8'h10, 8'h02, 8'h01};

  always #2 clk_i = ~clk_i;

  uhcsr_regs #(.RST_CNT(RCNT)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .usb_reset_i(usb_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sof_rx_i(hev[0]), .sof_timer_i(hev[1]), .resume_det_i(hev[2]),
    .suspend_det_i(hev[3]), .ep0_rx_done_i(hev[4]), .ep0_tx_done_i(hev[5]),
    .nak_stall_i(nak), .ep1_in_token_i(tok), .hub_suspended_i(susp),
    .overcurrent_in_n_i(ocn), .port_oc_n_i(pocn), .low_speed_i(lsp), .connect_i(conn),
    .conn_change_i(cchg), .port_error_i(3'h0), .resume_done_i(rdone),
    .irq_o(irq_o), .wake_o(wake_o), .remote_wake_req_o(rwake), .hub_addr_o(hub_addr_o),
    .port_se0_o(se0), .port_reset_o(prst), .port_power_o(pwr), .port_suspend_o(psus),
    .port_enable_o(pen), .ep1_send_o(send), .ep1_nak_o(ep1nak), .ep1_data_o(ep1_data_o));

  uhcsr_far_model u_far (
    .clk_i(clk_i), .reset_i(reset_i), .ev_i(ev), .glob_oc_i(glob_oc), .port_oc_i(p_oc),
    .attach_i(3'h7), .ls_dev_i(3'h2), .hub_ev_o(hev), .nak_o(nak), .token_o(tok),
    .conn_chg_o(cchg), .res_done_o(rdone), .oc_n_o(ocn), .port_oc_n_o(pocn),
    .low_speed_o(lsp), .connect_o(conn), .port_power_i(pwr), .ep1_send_i(send),
    .ep1_nak_i(ep1nak), .ep1_data_i(ep1_data_o), .resp_o(resp), .resp_data_o(resp_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o & m, e);
  endtask : rchk

  // event pulse through the far model, then n edges and settle
  task automatic pulse(input logic [13:0] e, input int n);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 14'h0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin : main
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk(ADR_SCRATCH, 8'hff, RST_ZERO);
    rchk(ADR_HADDR, 8'hff, RST_ZERO);
    rchk(ADR_IRQE, 8'hff, RST_ZERO);
    rchk(ADR_CFGST, 8'hfa, RST_CFGST);
    rchk(ADR_EP1CHG, 8'hff, RST_ZERO);
    rchk(ADR_PSTATE, 8'hff, RST_ZERO);
    rchk(8'h3c, 8'hff, RST_ZERO);
    chk({5'h0, se0}, 8'h07);
    $display("test reset values done");
    wr(ADR_SCRATCH, 8'ha5);
    wr(ADR_HADDR, 8'h45);
    rchk(ADR_HADDR, 8'hff, 8'h45);
    chk({1'b0, hub_addr_o}, 8'h45);
    @(posedge clk_i);
    usb_reset_i <= 1'b1;
    @(posedge clk_i);
    usb_reset_i <= 1'b0;
    rchk(ADR_SCRATCH, 8'hff, 8'ha5);
    rchk(ADR_HADDR, 8'hff, 8'h00);
    $display("test scratch and address done");
    for (int k = 0; k < 6; k++) begin
      pulse(14'(1) << k, 4);
      chk({7'h0, irq_o}, 8'h00);
      rchk(ADR_IRQF, 8'hff, fl[k]);
      rchk(ADR_IRQF, 8'hff, 8'h00);
      wr(ADR_IRQE, fl[k]);
      pulse(14'(1) << k, 4);
      chk({7'h0, irq_o}, 8'h01);
      if (k == 2) chk({7'h0, wake_o}, 8'h01);
      rchk(ADR_IRQF, 8'hff, fl[k]);
      wr(ADR_IRQE, 8'h00);
    end
    pulse(14'h0040, 1);
    chk({7'h0, irq_o}, 8'h00);
    wr(ADR_IRQE, 8'h80);
    pulse(14'h0040, 1);
    chk({7'h0, irq_o}, 8'h01);
    wr(ADR_IRQE, 8'h00);
    $display("test interrupts done");
    wr(ADR_CFGST, 8'h80);
    rchk(ADR_CFGST, 8'hf0, 8'h80);
    chk({5'h0, se0}, 8'h00);
    @(posedge clk_i);
    glob_oc <= 1'b1;
    repeat (4) @(posedge clk_i);
    rchk(ADR_CFGST, 8'h0a, 8'h0a);
    @(posedge clk_i);
    glob_oc <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(ADR_CFGST, 8'h0a, 8'h08);
    rchk(ADR_EP1CHG, 8'hff, 8'h01);
    pulse(14'h0080, 4);
    chk({6'h0, resp}, 8'h02);
    chk(resp_data, 8'h01);
    wr(ADR_CFGST, 8'h88);
    rchk(ADR_CFGST, 8'h08, 8'h00);
    pulse(14'h0080, 4);
    chk({6'h0, resp}, 8'h01);
    $display("test global status done");
    for (int p = 1; p < 4; p++) begin
      wr(ADR_PSEL, 8'(p));
      wr(ADR_PCMD, {5'h0, UHCSR_PWR_ON});
      rchk(ADR_PSTATE, 8'h20, 8'h20);
      wr(ADR_PCMD, {5'h0, UHCSR_RST_EN});
      rchk(ADR_PSTATE, 8'h12, 8'h10);
      chk({5'h0, prst}, 8'(1 << (p - 1)));
      repeat (RCNT + 8) @(posedge clk_i);
      rchk(ADR_PSTATE, 8'h7f, (p == 2) ? 8'h63 : 8'h23);
      chk({5'h0, pen}, 8'(1 << (p - 1)));
      chk({5'h0, prst}, 8'h00);
      rchk(ADR_PCHG, 8'h10, 8'h10);
      rchk(ADR_EP1CHG, 8'hff, 8'(1 << p));
      wr(ADR_PCHG, 8'h1f);
      rchk(ADR_EP1CHG, 8'hff, 8'h00);
      wr(ADR_PCMD, {5'h0, UHCSR_SUSPEND});
      rchk(ADR_PSTATE, 8'h04, 8'h04);
      chk({5'h0, psus}, 8'(1 << (p - 1)));
      wr(ADR_PCMD, {5'h0, UHCSR_RESUME});
      pulse(14'(1) << (10 + p), 4);
      rchk(ADR_PSTATE, 8'h04, 8'h00);
      rchk(ADR_PCHG, 8'h04, 8'h04);
      wr(ADR_PCHG, 8'h1f);
      wr(ADR_PCMD, {5'h0, UHCSR_DISABLE});
      rchk(ADR_PSTATE, 8'h02, 8'h00);
      wr(ADR_PCMD, {5'h0, UHCSR_PWR_OFF});
      rchk(ADR_PSTATE, 8'h20, 8'h00);
    end
    wr(ADR_PSEL, 8'h00);
    wr(ADR_PCMD, {5'h0, UHCSR_PWR_ON});
    rchk(ADR_PSTATE, 8'hff, 8'h00);
    chk({5'h0, pwr}, 8'h00);
    $display("test port commands done");
    wr(ADR_PSEL, 8'h01);
    wr(ADR_PCMD, {5'h0, UHCSR_PWR_ON});
    @(posedge clk_i);
    p_oc <= 3'h1;
    repeat (4) @(posedge clk_i);
    rchk(ADR_PSTATE, 8'h28, 8'h08);
    wr(ADR_CFGST, 8'h90);
    rchk(ADR_PSTATE, 8'h08, 8'h00);
    @(posedge clk_i);
    p_oc <= 3'h0;
    wr(ADR_CFGST, 8'ha0);
    wr(ADR_PCHG, 8'h1f);
    wr(ADR_PCMD, {5'h0, UHCSR_PWR_ON});
    repeat (3) @(posedge clk_i);
    chk({5'h0, pwr}, 8'h07);
    $display("test ganged modes done");
    @(posedge clk_i);
    susp <= 1'b1;
    pulse(14'h0100, 4);
    chk({7'h0, rwake}, 8'h00);
    wr(ADR_PCHG, 8'h1f);
    wr(ADR_CFGST, 8'he0);
    pulse(14'h0100, 4);
    chk({7'h0, rwake}, 8'h01);
    $display("test remote wake done");
    tally_and_finish();
  end
endmodule : usb_hub_control_status_regs_tb
